// >>> hdl/itoc_map.svh
/*
 * Offsets, fields, reset values and curve constants.
 * Assumes: Q16.16 times, Q4.12 currents, full energy at bit 24.
 */
`ifndef ITOC_MAP_SVH
`define ITOC_MAP_SVH

// ============================================================
// register byte offsets
`define ITOC_OFS_CTRL        8'h00
`define ITOC_OFS_PICKUP      8'h04
`define ITOC_OFS_PICKUP_HI   8'h08
`define ITOC_OFS_MULT        8'h0C
`define ITOC_OFS_STATUS      8'h10
`define ITOC_OFS_ENERGY      8'h14
`define ITOC_OFS_INT_STAT    8'h18
`define ITOC_OFS_INT_CLR     8'h1C
`define ITOC_OFS_INT_EN      8'h20
`define ITOC_OFS_USER_ADDR   8'h24
`define ITOC_OFS_USER_DATA   8'h28

// ============================================================
// fields and reset values
`define ITOC_CTRL_LINEAR_BIT 4
`define ITOC_UADDR_SEL_BIT   7
`define ITOC_INT_PICKUP      0
`define ITOC_INT_TRIP        1
`define ITOC_INT_DROPOUT     2
`define ITOC_PICKUP_RST      16'h1000
`define ITOC_MULT_RST        10'h064
`define ITOC_MULT_MAX        10'h3E8
`define ITOC_CURVE_RST       4'h0

// ============================================================
// arithmetic constants
`define ITOC_ONE             32'h00010000
`define ITOC_ENERGY_FULL     25'h1000000
`define ITOC_DROP_NUM        7'h31
`define ITOC_DROP_DEN        7'h32
`define ITOC_CR_STD          4'h5
`define ITOC_CR_IEC          4'h8
`define ITOC_DEF_BASE        32'h0000199A
`define ITOC_LN2             32'h0000B172
`define ITOC_USER_POINTS     80
`define ITOC_USER_STEP_SHIFT 13
`define ITOC_SAMPLE_US       1000
`define ITOC_PCT_SCALE       64'h64
`define ITOC_US_PER_S        64'hF4240

// ============================================================
// inverse curve rows {A, B, C, D, E}, Q16.16 signed
`define ITOC_ANSI_EI {32'h00000A37, 32'h00003ABA, 32'h00008000, \
                      32'h00030268, 32'h0000B8E2}
`define ITOC_ANSI_VI {32'h00000FBF, 32'h0000CC85, 32'h0000570A, \
                      32'hFFFFB74C, 32'h00040CEE}
`define ITOC_ANSI_NI {32'h00000704, 32'h000242EB, 32'h00004CCD, \
                      32'hFFFBCF63, 32'h00092090}
`define ITOC_ANSI_MI {32'h00002C6A, 32'h0000ADD9, 32'h0000CCCD, \
                      32'hFFFFEB85, 32'h0000208A}
// iec rows {K, E}, Q16.16
`define ITOC_IEC_A   {32'h000023D7, 32'h0000051F}
`define ITOC_IEC_B   {32'h000D8000, 32'h00010000}
`define ITOC_IEC_C   {32'h00500000, 32'h00020000}
`define ITOC_IEC_SI  {32'h00000CCD, 32'h00000A3D}

`endif

// >>> hdl/itoc_pkg.sv
/*
 * Types: curves, states, bus and sample carriers.
 * Assumes: compiled ahead of the core.
 */
package itoc_pkg;

    // ============================================================
    // curve shapes, in the order the curve field encodes them
    typedef enum logic [3:0] {
        curve_ansi_ext, curve_ansi_very, curve_ansi_norm, curve_ansi_mod,
        curve_vnd_ext, curve_vnd_very, curve_vnd_inv, curve_vnd_short,
        curve_iec_a, curve_iec_b, curve_iec_c, curve_iec_short,
        curve_definite, curve_user_a, curve_user_b
    } itoc_curve_type;

    typedef enum {
        st_idle, st_ratio, st_ansi1, st_ansi2, st_sum, st_rate, st_up,
        st_dec, st_div
    } itoc_state_type;

    // ============================================================
    // carriers
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } itoc_bus_type;

    typedef struct packed {
        logic valid;
        logic [15:0] mag;
    } itoc_sample_type;

endpackage : itoc_pkg

// >>> hdl/itoc_core.sv
/*
 * Overcurrent element: pickup, curves on one shared divider, energy,
 * reset methods, trip, register port, interrupt.
 * Assumes: samples spaced wider than one evaluation (247 cycles).
 */
`timescale 1ns/1ns
`include "itoc_map.svh"

// Functional notes
// [RULE1] start timing when current exceeds pickup
// [RULE2] dropout below 98 percent of pickup
// [RULE3] fifteen selectable curve shapes
// [RULE4] two user curves of 80 points
// [RULE5] curve evaluated only for ratio above one
// [RULE6] trip time proportional to multiplier
// [RULE7] zero multiplier trips at once
// [RULE8] trip when energy reaches full
// [RULE9] below dropout, reduce energy by method
// [RULE10] instantaneous method clears energy
// [RULE11] linear method ramps energy down steadily
// [RULE12] reset constant 5, or 8 for iec
// [RULE13] raised pickup level under special conditions
// [RULE14] definite time base 0.1 s times multiplier
// [RULE15] ansi formula with A to E terms
// [RULE16] iec formula K over ratio power minus one
// [RULE17] energy advances sample period over trip time
// [RULE18] reset clears energy, trip follows energy
module itoc_core #(
    parameter int SAMPLE_US = `ITOC_SAMPLE_US,
    parameter int USER_POINTS = `ITOC_USER_POINTS,
    parameter logic [639:0] VND_COEF = {`ITOC_ANSI_MI, `ITOC_ANSI_NI,
                                        `ITOC_ANSI_VI, `ITOC_ANSI_EI}
)(
    input wire logic clk_sys,
    input wire logic reset,
    input wire itoc_pkg::itoc_sample_type sample,
    input wire logic raise_pickup,
    input wire itoc_pkg::itoc_bus_type bus,
    output logic [31:0] rdata,
    output logic trip,
    output logic irq
);
    import itoc_pkg::*;

    localparam logic [47:0] RATE_NUM = 48'(((64'(SAMPLE_US)
        * `ITOC_PCT_SCALE) << 40) / `ITOC_US_PER_S);

    // ============================================================
    // functions
    function automatic logic [159:0] ansi_row(input logic [2:0] i);
        logic [159:0] r;
        r = VND_COEF[i[1:0]*160 +: 160];
        if (!i[2])
        begin
            case (i[1:0])
            2'h0: r = `ITOC_ANSI_EI;
            2'h1: r = `ITOC_ANSI_VI;
            2'h2: r = `ITOC_ANSI_NI;
            default: r = `ITOC_ANSI_MI;
            endcase
        end
        return r;
    endfunction : ansi_row

    function automatic logic [63:0] iec_row(input logic [1:0] i);
        logic [63:0] r;
        case (i)
        2'h0: r = `ITOC_IEC_A;
        2'h1: r = `ITOC_IEC_B;
        2'h2: r = `ITOC_IEC_C;
        default: r = `ITOC_IEC_SI;
        endcase
        return r;
    endfunction : iec_row

    // linear mantissa log2, within 0.09 of the true value
    function automatic logic [31:0] log2q(input logic [31:0] r);
        logic [4:0] p;
        logic [31:0] sh;
        p = 5'h10;
        for (int k = 16; k < 32; k++)
        begin
            if (r[k])
                p = 5'(k);
        end
        sh = r << (5'h1F - p);
        return {11'h0, p - 5'h10, sh[30:15]};
    endfunction : log2q

    function automatic logic [7:0] tab_index(input logic sel,
                                             input logic [6:0] idx);
        return sel ? 8'(idx) + 8'(USER_POINTS) : 8'(idx);
    endfunction : tab_index

    function automatic logic [47:0] snum(input logic signed [31:0] a);
        logic [31:0] m;
        m = a[31] ? 32'(-a) : 32'(a);
        return {m, 16'h0};
    endfunction : snum

    // ============================================================
    // state
    itoc_state_type state_q, state_d, ret_q, ret_d, div_ret;
    itoc_curve_type curve_q, curve_d;
    logic [31:0] ratio_q, ratio_d, x_q, x_d;
    logic signed [31:0] base_q, base_d;
    logic [24:0] energy_q, energy_d;
    logic picked_q, picked_d, trip_q;
    logic [47:0] dnum_q, dnum_d, dden_q, dden_d, drem_q, drem_d;
    logic [5:0] dcnt_q, dcnt_d;
    logic dneg_q, dneg_d;
    logic div_go, div_ng;
    logic [47:0] div_n, div_dv;

    logic [3:0] ctrl_curve_q;
    logic ctrl_lin_q;
    logic [15:0] pickup_q, pickup_hi_q;
    logic [9:0] mult_q;
    logic [2:0] int_stat_q, int_en_q;
    logic [7:0] uaddr_q;
    logic [31:0] utab [2*USER_POINTS];
    logic [31:0] rdata_q;

    // ============================================================
    // pickup and dropout decode
    logic [15:0] pk;
    logic above, below;
    assign pk = raise_pickup ? pickup_hi_q : pickup_q; // [RULE13]
    assign above = sample.mag > pk; // [RULE1]
    assign below = 23'(sample.mag) * 23'(`ITOC_DROP_DEN)
                 < 23'(pk) * 23'(`ITOC_DROP_NUM); // [RULE2]

    // ============================================================
    // divider datapath and curve decode
    logic [31:0] quo_sat;
    logic signed [31:0] div_res;
    logic [48:0] rem_sh;
    logic fits;
    assign quo_sat = (|dnum_q[47:31]) ? 32'h7FFFFFFF : dnum_q[31:0];
    assign div_res = dneg_q ? -$signed(quo_sat) : $signed(quo_sat);
    assign rem_sh = {drem_q, dnum_q[47]};
    assign fits = rem_sh >= {1'b0, dden_q};

    logic [159:0] arow;
    logic [63:0] irow;
    logic is_ansi, is_iec;
    logic [3:0] cr;
    assign arow = ansi_row(curve_q[2:0]);
    assign irow = iec_row(curve_q[1:0]);
    assign is_ansi = curve_q <= curve_vnd_short;
    assign is_iec = (curve_q >= curve_iec_a) && (curve_q <= curve_iec_short);
    assign cr = is_iec ? `ITOC_CR_IEC : `ITOC_CR_STD; // [RULE12]

    // iec denominator from the fresh ratio; small exponents use a series
    logic [31:0] rq, lnr, yq, sq_r, iec_den;
    logic [63:0] r2, el;
    assign rq = quo_sat;
    assign r2 = 64'(rq) * 64'(rq);
    assign lnr = 32'((64'(log2q(rq)) * 64'(`ITOC_LN2)) >> 16);
    assign el = (64'(irow[31:0]) * 64'(lnr)) >> 16;
    assign yq = el[31:0];
    assign sq_r = (|r2[63:48]) ? 32'h7FFFFFFF : r2[47:16];
    assign iec_den = (curve_q == curve_iec_b) ? rq - `ITOC_ONE
                   : (curve_q == curve_iec_c) ? sq_r - `ITOC_ONE
                   : yq + 32'((64'(yq) * 64'(yq)) >> 17); // [RULE16]

    logic [31:0] bucket_w, user_t;
    logic [6:0] bucket;
    assign bucket_w = (rq - `ITOC_ONE) >> `ITOC_USER_STEP_SHIFT;
    assign bucket = (bucket_w > 32'(USER_POINTS - 1)) ?
                    7'(USER_POINTS - 1) : bucket_w[6:0];
    assign user_t = utab[tab_index(curve_q == curve_user_b, bucket)]; // [RULE4]

    logic [48:0] up_sum;
    logic signed [31:0] base_pos;
    assign up_sum = 49'(energy_q) + {1'b0, dnum_q};
    assign base_pos = (base_q > 0) ? base_q : 32'sh1;

    // ============================================================
    // evaluation sequence
    always_comb
    begin
        state_d = state_q;
        ret_d = ret_q;
        curve_d = curve_q;
        ratio_d = ratio_q;
        x_d = x_q;
        base_d = base_q;
        energy_d = energy_q;
        picked_d = picked_q;
        dnum_d = dnum_q;
        dden_d = dden_q;
        drem_d = drem_q;
        dcnt_d = dcnt_q;
        dneg_d = dneg_q;
        div_go = 1'b0;
        div_ng = 1'b0;
        div_n = '0;
        div_dv = '0;
        div_ret = st_idle;
        case (state_q)
        st_idle:
        begin
            if (sample.valid)
            begin
                curve_d = itoc_curve_type'(ctrl_curve_q); // [RULE3]
                if (above)
                begin
                    picked_d = 1'b1;
                    if (mult_q == 10'h0)
                        energy_d = `ITOC_ENERGY_FULL; // [RULE7]
                    else
                    begin
                        div_go = 1'b1;
                        div_n = {16'h0, sample.mag, 16'h0};
                        div_dv = 48'(pk);
                        div_ret = st_ratio;
                    end
                end
                else if (below)
                begin
                    picked_d = 1'b0;
                    if (!ctrl_lin_q || mult_q == 10'h0)
                        energy_d = '0; // [RULE9] [RULE10]
                    else if (energy_q != '0)
                    begin
                        div_go = 1'b1; // [RULE11]
                        div_n = RATE_NUM;
                        div_dv = 48'(14'(mult_q) * 14'(cr)) << 16;
                        div_ret = st_dec;
                    end
                end
            end
        end
        st_ratio:
        begin
            ratio_d = quo_sat;
            x_d = quo_sat - arow[95:64];
            if (quo_sat <= `ITOC_ONE)
                state_d = st_idle; // [RULE5]
            else if (is_ansi)
            begin
                div_go = 1'b1; // [RULE15]
                div_n = snum(arow[31:0]);
                div_ng = arow[31];
                div_dv = 48'(quo_sat - arow[95:64]);
                div_ret = st_ansi1;
            end
            else if (is_iec)
            begin
                div_go = 1'b1;
                div_n = snum(irow[63:32]);
                div_dv = 48'(iec_den);
                div_ret = st_sum;
            end
            else
            begin
                base_d = (curve_q == curve_definite) ?
                         `ITOC_DEF_BASE : user_t; // [RULE14]
                state_d = st_rate;
            end
        end
        st_ansi1, st_ansi2:
        begin
            div_go = 1'b1;
            div_n = snum((state_q == st_ansi1 ? arow[63:32] : arow[127:96])
                         + div_res);
            div_ng = (state_q == st_ansi1 ? arow[63:32] : arow[127:96])
                     + div_res < 0;
            div_dv = 48'(x_q);
            div_ret = (state_q == st_ansi1) ? st_ansi2 : st_sum;
        end
        st_sum:
        begin
            base_d = (is_ansi ? $signed(arow[159:128]) : 32'sh0) + div_res;
            state_d = st_rate;
        end
        st_rate:
        begin
            div_go = 1'b1; // [RULE6] [RULE17]
            div_n = RATE_NUM;
            div_dv = 48'(42'(mult_q) * 42'(base_pos));
            div_ret = st_up;
        end
        st_up:
        begin
            energy_d = (up_sum >= 49'(`ITOC_ENERGY_FULL)) ?
                       `ITOC_ENERGY_FULL : up_sum[24:0]; // [RULE8]
            state_d = st_idle;
        end
        st_dec:
        begin
            energy_d = (49'(energy_q) > {1'b0, dnum_q}) ?
                       energy_q - dnum_q[24:0] : '0; // [RULE11]
            state_d = st_idle;
        end
        st_div:
        begin
            dnum_d = {dnum_q[46:0], fits};
            drem_d = fits ? 48'(rem_sh - {1'b0, dden_q}) : rem_sh[47:0];
            dcnt_d = dcnt_q + 6'h1;
            if (dcnt_q == 6'h2F)
                state_d = ret_q;
        end
        default:
            state_d = st_idle;
        endcase
        if (div_go)
        begin
            state_d = st_div;
            ret_d = div_ret;
            dnum_d = div_n;
            dden_d = div_dv;
            drem_d = '0;
            dcnt_d = '0;
            dneg_d = div_ng;
        end
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            state_q <= st_idle;
            ret_q <= st_idle;
            curve_q <= curve_ansi_ext;
            {ratio_q, x_q, base_q} <= '0;
            {dnum_q, dden_q, drem_q, dcnt_q, dneg_q} <= '0;
            energy_q <= '0; // [RULE18]
            picked_q <= 1'b0;
            trip_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            ret_q <= ret_d;
            curve_q <= curve_d;
            {ratio_q, x_q, base_q} <= {ratio_d, x_d, base_d};
            {dnum_q, dden_q, drem_q} <= {dnum_d, dden_d, drem_d};
            {dcnt_q, dneg_q} <= {dcnt_d, dneg_d};
            energy_q <= energy_d;
            picked_q <= picked_d;
            trip_q <= energy_d[24]; // [RULE8] [RULE18]
        end
    end

    // ============================================================
    // register port
    logic wr_ctrl, wr_pk, wr_pkhi, wr_mult, wr_clr, wr_en, wr_ua, wr_ud;
    logic [2:0] ev, int_stat_d;
    logic [9:0] mult_w;
    logic [7:0] ua_idx;
    logic [31:0] rd_val;
    assign wr_ctrl = bus.wr && bus.addr == `ITOC_OFS_CTRL;
    assign wr_pk = bus.wr && bus.addr == `ITOC_OFS_PICKUP;
    assign wr_pkhi = bus.wr && bus.addr == `ITOC_OFS_PICKUP_HI;
    assign wr_mult = bus.wr && bus.addr == `ITOC_OFS_MULT;
    assign wr_clr = bus.wr && bus.addr == `ITOC_OFS_INT_CLR;
    assign wr_en = bus.wr && bus.addr == `ITOC_OFS_INT_EN;
    assign wr_ua = bus.wr && bus.addr == `ITOC_OFS_USER_ADDR;
    assign wr_ud = bus.wr && bus.addr == `ITOC_OFS_USER_DATA
                   && uaddr_q[6:0] < 7'(USER_POINTS);
    assign mult_w = (bus.wdata[9:0] > `ITOC_MULT_MAX) ?
                    `ITOC_MULT_MAX : bus.wdata[9:0];
    assign ua_idx = tab_index(uaddr_q[`ITOC_UADDR_SEL_BIT], uaddr_q[6:0]);
    // a new event wins over a clear in the same cycle
    assign ev = {picked_q & ~picked_d, ~trip_q & energy_d[24],
                 ~picked_q & picked_d};
    assign int_stat_d = (int_stat_q & ~(wr_clr ? bus.wdata[2:0] : 3'h0))
                        | ev;

    always_comb
    begin
        case (bus.addr)
        `ITOC_OFS_CTRL: rd_val = {27'h0, ctrl_lin_q, ctrl_curve_q};
        `ITOC_OFS_PICKUP: rd_val = {16'h0, pickup_q};
        `ITOC_OFS_PICKUP_HI: rd_val = {16'h0, pickup_hi_q};
        `ITOC_OFS_MULT: rd_val = {22'h0, mult_q};
        `ITOC_OFS_STATUS: rd_val = {29'h0, state_q != st_idle, trip_q,
                                    picked_q};
        `ITOC_OFS_ENERGY: rd_val = {7'h0, energy_q};
        `ITOC_OFS_INT_STAT: rd_val = {29'h0, int_stat_q};
        `ITOC_OFS_INT_EN: rd_val = {29'h0, int_en_q};
        `ITOC_OFS_USER_ADDR: rd_val = {24'h0, uaddr_q};
        `ITOC_OFS_USER_DATA: rd_val = utab[ua_idx];
        default: rd_val = 32'h0;
        endcase
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            ctrl_curve_q <= `ITOC_CURVE_RST;
            ctrl_lin_q <= 1'b0;
            pickup_q <= `ITOC_PICKUP_RST;
            pickup_hi_q <= `ITOC_PICKUP_RST;
            mult_q <= `ITOC_MULT_RST;
            int_stat_q <= 3'h0;
            int_en_q <= 3'h0;
            uaddr_q <= 8'h0;
            rdata_q <= 32'h0;
        end
        else
        begin
            if (wr_ctrl)
                {ctrl_lin_q, ctrl_curve_q} <= bus.wdata[4:0];
            if (wr_pk)
                pickup_q <= bus.wdata[15:0];
            if (wr_pkhi)
                pickup_hi_q <= bus.wdata[15:0];
            if (wr_mult)
                mult_q <= mult_w;
            if (wr_en)
                int_en_q <= bus.wdata[2:0];
            if (wr_ua)
                uaddr_q <= bus.wdata[7:0];
            int_stat_q <= int_stat_d;
            rdata_q <= bus.rd ? rd_val : 32'h0;
        end
    end

    // table memory holds no reset; software loads it before use
    always_ff @(posedge clk_sys)
    begin
        if (wr_ud)
            utab[ua_idx] <= bus.wdata; // [RULE4]
    end

    assign rdata = rdata_q;
    assign trip = trip_q;
    assign irq = |(int_stat_q & int_en_q);

endmodule : itoc_core

// >>> tb/itoc_monitor.sv
/*
 * Port assertions on itoc_core, bound to it.
 * Assumes samples spaced wider than one evaluation.
 */
`timescale 1ns/1ns
`include "itoc_map.svh"
module itoc_monitor (
    input wire logic clk_sys,
    input wire logic reset,
    input wire itoc_pkg::itoc_sample_type sample,
    input wire logic raise_pickup,
    input wire itoc_pkg::itoc_bus_type bus,
    input wire logic [31:0] rdata,
    input wire logic trip,
    input wire logic irq
);
    import itoc_pkg::*;
    // ========
    // shadow of settings
    logic [15:0] pk_q, pkh_q;
    logic mz_q, lin_q;
    logic [9:0] age_q;
    wire [7:0] wa = bus.addr;
    wire [15:0] pk = raise_pickup ? pkh_q : pk_q;
    wire above = sample.mag > pk;
    wire below = 32'(sample.mag) * 50 < 32'(pk) * 49;
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            {pk_q, pkh_q} <= {2{`ITOC_PICKUP_RST}};
            {mz_q, lin_q, age_q} <= {2'b00, 10'h3FF};
        end
        else
        begin
            if (bus.wr && wa == `ITOC_OFS_PICKUP)
                pk_q <= bus.wdata[15:0];
            if (bus.wr && wa == `ITOC_OFS_PICKUP_HI)
                pkh_q <= bus.wdata[15:0];
            // the core keeps only the low ten multiplier bits
            if (bus.wr && wa == `ITOC_OFS_MULT)
                mz_q <= bus.wdata[9:0] == 10'h000;
            if (bus.wr && wa == `ITOC_OFS_CTRL)
                lin_q <= bus.wdata[`ITOC_CTRL_LINEAR_BIT];
            // saturate so a long quiet spell never wraps
            age_q <= sample.valid ? 10'h000
                   : age_q + 10'(age_q != 10'h3FF);
        end
    end
    // ========
    // assertions
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);
    instant_trip_a: assert property (
        sample.valid && above && mz_q |=> trip)
        else $error("no instant trip");
    instant_drop_a: assert property (
        sample.valid && below && !lin_q |=> !trip)
        else $error("trip kept after dropout");
    hold_zone_a: assert property (
        sample.valid && !above && !below && trip |=> trip)
        else $error("trip lost in band");
    linear_fall_a: assert property (
        sample.valid && below && lin_q && !mz_q && trip
        |-> ##[1:300] !trip)
        else $error("linear reset kept trip");
    trip_rise_a: assert property (
        $rose(trip) |-> age_q < 10'h12C)
        else $error("trip rose late");
    trip_fall_a: assert property (
        $fell(trip) |-> age_q < 10'h12C)
        else $error("trip fell late");
    reset_clear_a: assert property (
        $fell(reset) |-> !trip && !irq && rdata == 32'h0)
        else $error("outputs set after reset");
    rdata_idle_a: assert property (
        !$past(bus.rd) |-> rdata == 32'h0)
        else $error("stray read data");
endmodule : itoc_monitor

bind itoc_core itoc_monitor mon (.clk_sys(clk_sys), .reset(reset),
    .sample(sample), .raise_pickup(raise_pickup), .bus(bus),
    .rdata(rdata), .trip(trip), .irq(irq));

// >>> tb/itoc_front.sv
/*
 * Current measurement front end, one sample per go.
 * Assumes go only while done is high.
 */
`timescale 1ns/1ns
module itoc_front (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic go,
    input wire logic [15:0] mag,
    output itoc_pkg::itoc_sample_type sample,
    output logic done
);
    import itoc_pkg::*;
    logic [8:0] gap_q;
    itoc_sample_type smp_q;
    // word flips between samples so nothing leans on a stale value
    wire [15:0] mag_d = go ? mag : ~smp_q.mag;
    // spacing beyond the slowest evaluation
    wire [8:0] gap_d = go ? 9'h12C : gap_q - {8'h00, gap_q != 9'h000};
    assign done = gap_q == 9'h000 && !go;
    assign sample = smp_q;
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            smp_q <= '0;
            gap_q <= 9'h000;
        end
        else
        begin
            smp_q <= {go, mag_d};
            gap_q <= gap_d;
        end
    end
endmodule : itoc_front

// >>> tb/testbench.sv
/*
 * Self-checking run of itoc_core with a front-end model.
 * Assumes a 0.1 s sample period.
 */
`timescale 1ns/1ns
`include "itoc_map.svh"
module testbench;
    import itoc_pkg::*;
    logic clk_sys, reset, raise_pickup, go, done, trip, irq;
    logic [15:0] mag;
    logic [31:0] rdata, v, e;
    itoc_bus_type bus;
    itoc_sample_type sample;
    int num_errors = 0;
    int checks_done = 0;
    int seed = 32'hA39194CB;
    localparam logic [31:0] FULL = `ITOC_ENERGY_FULL;
    localparam logic [7:0] RA [7] = '{8'h00, 8'h04, 8'h08, 8'h0C,
                                      8'h20, 8'h14, 8'h40};
    localparam logic [31:0] RV [7] = '{32'h0, 32'h1000, 32'h1000,
                                       32'h64, 32'h0, 32'h0, 32'h0};
    itoc_core #(.SAMPLE_US(100000)) uut (.clk_sys(clk_sys),
        .reset(reset), .sample(sample), .raise_pickup(raise_pickup),
        .bus(bus), .rdata(rdata), .trip(trip), .irq(irq));
    itoc_front front (.clk_sys(clk_sys), .reset(reset), .go(go),
        .mag(mag), .sample(sample), .done(done));
    initial
    begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    // ========
    // expectations and checks
    function automatic logic [31:0] gain(input int num, input int den);
        return 32'(64'(FULL) * num / den);
    endfunction : gain
    function automatic logic [31:0] near(input logic [31:0] s,
                                         input logic [31:0] x);
        return (s > x - (x >> 7) && s < x + (x >> 7)) ? x : s;
    endfunction : near
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time,
                     seen, exp);
        end
    endtask : check
    task automatic ctrip(input logic x);
        @(negedge clk_sys);
        check(32'(trip), 32'(x));
    endtask : ctrip
    task automatic cirq(input logic x);
        @(negedge clk_sys);
        check(32'(irq), 32'(x));
    endtask : cirq
    // ========
    // bus and sample drivers
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        bus <= {a, d, 2'b10};
        @(posedge clk_sys);
        bus <= '0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        bus <= {a, 32'h0, 2'b01};
        @(posedge clk_sys);
        bus <= '0;
        @(negedge clk_sys);
        v = rdata;
    endtask : rd
    task automatic send(input logic [15:0] m);
        @(posedge clk_sys);
        mag <= m;
        go <= 1'b1;
        @(posedge clk_sys);
        go <= 1'b0;
        @(negedge clk_sys);
        for (int i = 0; i < 400 && done !== 1'b1; i++)
            @(negedge clk_sys);
    endtask : send
    task automatic summarize;
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : summarize
    initial
    begin
        repeat (60000) @(posedge clk_sys);
        num_errors++;
        summarize();
    end
    // ========
    // scenarios
    initial
    begin
        reset = 1'b1;
        raise_pickup = 1'b0;
        go = 1'b0;
        mag = 16'h0000;
        bus = '0;
        repeat (4) @(posedge clk_sys);
        reset <= 1'b0;
        for (int i = 0; i < 7; i++)
        begin
            rd(RA[i]);
            check(v, RV[i]);
        end
        wr(`ITOC_OFS_MULT, 32'h7FF);
        rd(`ITOC_OFS_MULT);
        check(v, 32'h3E8);
        wr(`ITOC_OFS_INT_EN, 32'h7);
        wr(`ITOC_OFS_MULT, 32'h0);
        for (int c = 0; c < 15; c++)
        begin
            wr(`ITOC_OFS_CTRL, 32'(c));
            send(16'h1001 + 16'($unsigned($random(seed)) % 32'hE000));
            ctrip(1'b1);
            send(16'($unsigned($random(seed)) % 32'hFAE));
            ctrip(1'b0);
        end
        rd(`ITOC_OFS_INT_STAT);
        check(v, 32'h7);
        cirq(1'b1);
        wr(`ITOC_OFS_INT_CLR, 32'h7);
        rd(`ITOC_OFS_INT_STAT);
        check(v, 32'h0);
        cirq(1'b0);
        wr(`ITOC_OFS_INT_EN, 32'h0);
        send(16'h2000);
        cirq(1'b0);
        wr(`ITOC_OFS_INT_EN, 32'h2);
        cirq(1'b1);
        send(16'hFAF);
        ctrip(1'b1);
        send(16'hFAE);
        ctrip(1'b0);
        wr(`ITOC_OFS_PICKUP_HI, 32'h2000);
        @(posedge clk_sys);
        raise_pickup <= 1'b1;
        send(16'h1800);
        ctrip(1'b0);
        @(posedge clk_sys);
        raise_pickup <= 1'b0;
        send(16'h1800);
        ctrip(1'b1);
        wr(`ITOC_OFS_CTRL, 32'hC);
        wr(`ITOC_OFS_MULT, 32'h32);
        send(16'h0000);
        send(16'h1000);
        rd(`ITOC_OFS_ENERGY);
        check(v, 32'h0);
        for (int m = 150; m <= 300; m += 150)
        begin
            wr(`ITOC_OFS_MULT, 32'(m));
            send(16'h2000);
            rd(`ITOC_OFS_ENERGY);
            check(near(v, gain(100, m)), gain(100, m));
            send(16'h0000);
        end
        wr(`ITOC_OFS_MULT, 32'h96);
        send(16'h2000);
        send(16'h2000);
        ctrip(1'b1);
        rd(`ITOC_OFS_ENERGY);
        check(v, FULL);
        wr(`ITOC_OFS_MULT, 32'h64);
        wr(`ITOC_OFS_CTRL, 32'h19);
        send(16'h0000);
        e = FULL - gain(10, 800);
        rd(`ITOC_OFS_ENERGY);
        check(near(v, e), e);
        ctrip(1'b0);
        wr(`ITOC_OFS_CTRL, 32'h1C);
        send(16'h0000);
        e = e - gain(10, 500);
        rd(`ITOC_OFS_ENERGY);
        check(near(v, e), e);
        wr(`ITOC_OFS_CTRL, 32'hC);
        send(16'h0000);
        rd(`ITOC_OFS_ENERGY);
        check(v, 32'h0);
        for (int i = 0; i < 80; i++)
        begin
            wr(`ITOC_OFS_USER_ADDR, 32'(i));
            wr(`ITOC_OFS_USER_DATA, 32'h199A);
        end
        wr(`ITOC_OFS_USER_ADDR, 32'h50);
        wr(`ITOC_OFS_USER_DATA, 32'h0);
        wr(`ITOC_OFS_USER_ADDR, 32'h0);
        rd(`ITOC_OFS_USER_DATA);
        check(v, 32'h199A);
        wr(`ITOC_OFS_CTRL, 32'hD);
        wr(`ITOC_OFS_MULT, 32'h32);
        send(16'h2000);
        ctrip(1'b1);
        summarize();
    end
endmodule : testbench
